// File: rtl/line_cfg.sv
// line termination config, billing tone detect and status with an axi4-lite slave
// Behaviour
// [R1] two-bit field selects four dc terminations
// [R2] dc field resets to default mode 10
// [R3] code 11 applies current limiting termination
// [R4] codes 01/00 attenuate transmit 1.7/4 dB
// [R5] bit 4 selects real or complex ac
// [R6] bit 1 enables synthesized ringer impedance
// [R7] host sets headroom bit only when allowed
// [R8] default mode overrides give low loop or low voltage, no attenuation
// [R9] override bits ignored outside default mode
// [R10] host dials DTMF via default mode override
// [R11] host pulse dials by toggling hook
// [R12] ramp field controls slow on-hook current
// [R13] detection only while detect-enable set
// [R14] overload sets sticky overload flag
// [R15] supply droop sets sticky tone flag
// [R16] tone flag forces 800 ohm termination
// [R17] sticky flags clear only on zero write
// [R18] detect disable restores termination after ~1s
// [R19] host polls live overload then disables
// [R20] host clears all bits before re-arming
// [R21] host qualifies multiple events before deciding
// [R22] stay off-hook during billing tone event
// [R23] live overload flag at status bit 6
// [R24] config fields hold until rewrite or reset
module line_cfg
    import line_cfg_pkg::*;
#(
    parameter int restore_count = restore_cycles
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic offhook_req,
    input wire logic overload_pin,
    input wire logic supply_droop_pin,
    output line_drive_t line_drive
);
    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [7:0] w_data;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] func;
        logic [7:0] cfg;
        logic [7:0] dial;
        logic ovl_sticky;
        logic tone_seen;
        logic tone_latched;
        logic [31:0] restore_cnt;
        logic [1:0] ovl_sync;
        logic [1:0] droop_sync;
        logic [1:0] hook_sync;
        line_drive_t drive;
    } state_t;

    state_t st;
    state_t next_st;
    logic [7:0] status_view;
    logic wr_go;
    logic ovl_now;
    logic droop_now;
    logic [1:0] mode;
    logic ovr_a;
    logic ovr_b;

    always_comb begin
        ovl_now = st.ovl_sync[1];
        droop_now = st.droop_sync[1];
        mode = st.cfg[dc_term_mode_lo +: 2];
        ovr_a = st.dial[low_loop_a_bit];
        ovr_b = st.dial[low_loop_b_bit];
        status_view = line_status_reserved;
        status_view[overload_sticky_bit] = st.ovl_sticky;
        status_view[tone_seen_bit] = st.tone_seen;
        status_view[overload_live_bit] = ovl_now; // R23
        wr_go = st.aw_held && st.w_held && !st.bvalid;
        next_st = st;
        // ************************************************************
        // pin synchronisers
        // ************************************************************
        next_st.ovl_sync = {st.ovl_sync[0], overload_pin};
        next_st.droop_sync = {st.droop_sync[0], supply_droop_pin};
        next_st.hook_sync = {st.hook_sync[0], offhook_req};
        // ************************************************************
        // axi write channel: address and data taken in either order
        // ************************************************************
        if (s_axi_awvalid && !st.aw_held) begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st.w_held) begin
            next_st.w_held = 1'b1;
            next_st.w_data = s_axi_wdata[7:0];
            next_st.w_lane0 = s_axi_wstrb[0];
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        // ************************************************************
        // flag setting; a set in the clearing cycle wins below
        // ************************************************************
        if (wr_go) begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = axi_okay;
            if (st.aw_addr == line_function_reg_off) begin
                if (st.w_lane0) begin
                    next_st.func = st.w_data; // R24
                end
            end else if (st.aw_addr == line_config_reg_off) begin
                if (st.w_lane0) begin
                    next_st.cfg = st.w_data; // R24
                end
            end else if (st.aw_addr == dial_control_reg_off) begin
                if (st.w_lane0) begin
                    next_st.dial = st.w_data; // R24
                end
            end else if (st.aw_addr == line_status_reg_off) begin
                // only a zero written clears a sticky flag
                if (st.w_lane0 && !st.w_data[overload_sticky_bit]) begin
                    next_st.ovl_sticky = 1'b0; // R17
                end
                if (st.w_lane0 && !st.w_data[tone_seen_bit]) begin
                    next_st.tone_seen = 1'b0; // R17
                end
            end else if (st.aw_addr != line_drive_reg_off) begin
                next_st.bresp = axi_slverr;
            end
        end
        if (st.func[tone_detect_enable_bit]) begin // R13
            if (ovl_now) begin
                next_st.ovl_sticky = 1'b1; // R14
            end
            if (droop_now) begin
                next_st.tone_seen = 1'b1; // R15
                next_st.tone_latched = 1'b1; // R16
            end
        end
        // ************************************************************
        // 800 ohm hold until detect disable, then timed restore
        // ************************************************************
        if (st.tone_latched && !st.func[tone_detect_enable_bit]) begin
            if (st.restore_cnt >= 32'(restore_count - 1)) begin
                next_st.tone_latched = 1'b0; // R18
                next_st.restore_cnt = '0;
            end else begin
                next_st.restore_cnt = st.restore_cnt + 32'h1;
            end
        end else begin
            next_st.restore_cnt = '0;
        end
        // ************************************************************
        // axi read channel
        // ************************************************************
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !st.rvalid) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = axi_okay;
            next_st.rdata = '0;
            if (s_axi_araddr == line_function_reg_off) begin
                next_st.rdata[7:0] = st.func;
            end else if (s_axi_araddr == line_config_reg_off) begin
                next_st.rdata[7:0] = st.cfg;
            end else if (s_axi_araddr == dial_control_reg_off) begin
                next_st.rdata[7:0] = st.dial;
            end else if (s_axi_araddr == line_status_reg_off) begin
                next_st.rdata[7:0] = status_view;
            end else if (s_axi_araddr == line_drive_reg_off) begin
                next_st.rdata[12:0] = st.drive;
            end else begin
                next_st.rresp = axi_slverr;
            end
        end
        // ************************************************************
        // line drive decode
        // ************************************************************
        case (mode) // R1
            dc_mode_low_voltage: next_st.drive.term = term_low_voltage;
            dc_mode_low_loop: next_st.drive.term = term_low_loop;
            dc_mode_current_limit: next_st.drive.term = term_current_limit; // R3
            default: begin
                // overrides only honoured in default mode
                if (ovr_a) begin
                    next_st.drive.term = term_low_loop; // R8 R9
                end else if (ovr_b) begin
                    next_st.drive.term = term_low_voltage; // R8 R9
                end else begin
                    next_st.drive.term = term_default;
                end
            end
        endcase
        if (st.tone_latched) begin
            next_st.drive.term = term_800_ohm; // R16
        end
        next_st.drive.tx_atten_1p7db = (mode == dc_mode_low_loop); // R4
        next_st.drive.tx_atten_4db = (mode == dc_mode_low_voltage); // R4
        next_st.drive.ac_complex = st.cfg[ac_impedance_sel_bit]; // R5
        next_st.drive.ringer_synth = st.cfg[ringer_impedance_synth_bit]; // R6
        // headroom bit passed through only in current limit mode; held low in the other modes
        next_st.drive.dial_headroom = (mode == dc_mode_current_limit) && st.dial[dial_headroom_bit]; // R7
        next_st.drive.onhook_ramp = st.cfg[onhook_ramp_lo +: 2]; // R12
        // hook follows host only; tone events never drop the line
        next_st.drive.offhook_hold = st.hook_sync[1]; // R22 R11
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.func <= line_function_reset;
            st.cfg <= line_config_reset; // R2
            st.dial <= dial_control_reset;
            st.drive.term <= term_default;
        end else begin
            st <= next_st;
        end
    end

    assign s_axi_awready = !st.aw_held;
    assign s_axi_wready = !st.w_held;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = !st.rvalid;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;
    assign line_drive = st.drive;
endmodule

// File: shared/line_cfg_pkg.sv
// package: register map, field positions, reset values and timing for the line config block
package line_cfg_pkg;
    // ************************************************************
    // register byte offsets
    // ************************************************************
    localparam logic [7:0] line_function_reg_off = 8'h00;
    localparam logic [7:0] line_config_reg_off = 8'h04;
    localparam logic [7:0] dial_control_reg_off = 8'h08;
    localparam logic [7:0] line_status_reg_off = 8'h0c;
    localparam logic [7:0] line_drive_reg_off = 8'h10;
    // ************************************************************
    // field positions
    // ************************************************************
    localparam int tone_detect_enable_bit = 7;
    localparam int ringer_impedance_synth_bit = 1;
    localparam int dc_term_mode_lo = 2;
    localparam int ac_impedance_sel_bit = 4;
    localparam int onhook_ramp_lo = 5;
    localparam int low_loop_a_bit = 3;
    localparam int dial_headroom_bit = 2;
    localparam int low_loop_b_bit = 0;
    localparam int overload_sticky_bit = 1;
    localparam int tone_seen_bit = 3;
    localparam int overload_live_bit = 6;
    // ************************************************************
    // reset values and encodings
    // ************************************************************
    localparam logic [7:0] line_function_reset = 8'h00;
    localparam logic [7:0] line_config_reset = 8'h08;
    localparam logic [7:0] dial_control_reset = 8'h00;
    localparam logic [7:0] line_status_reserved = 8'h20;
    localparam logic [1:0] dc_mode_low_voltage = 2'h0;
    localparam logic [1:0] dc_mode_low_loop = 2'h1;
    localparam logic [1:0] dc_mode_default = 2'h2;
    localparam logic [1:0] dc_mode_current_limit = 2'h3;
    // ************************************************************
    // timing: restore of original dc termination after detect disable
    // ************************************************************
    localparam int clock_mhz = 250;
    localparam int restore_time_ms = 1000;
    localparam int restore_cycles = restore_time_ms * 1000 * clock_mhz;
    localparam logic [1:0] axi_okay = 2'h0;
    localparam logic [1:0] axi_slverr = 2'h2;

    // ************************************************************
    // line drive word handed to the analog line side
    // ************************************************************
    typedef enum logic [4:0] {
        term_low_voltage = 5'h01,
        term_low_loop = 5'h02,
        term_default = 5'h04,
        term_current_limit = 5'h08,
        term_800_ohm = 5'h10
    } dc_term_t;

    typedef struct packed {
        dc_term_t term;
        logic tx_atten_1p7db;
        logic tx_atten_4db;
        logic ac_complex;
        logic ringer_synth;
        logic dial_headroom;
        logic [1:0] onhook_ramp;
        logic offhook_hold;
    } line_drive_t;
endpackage

// File: testbench/line_side_model.sv
// line-side model: raises overload and supply droop while a tone burst sits on the line
module line_side_model
    import line_cfg_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic burst,
    input wire line_drive_t line_drive,
    output logic overload_pin,
    output logic supply_droop_pin
);
    logic [1:0] age;
    // ************************************************************
    // tone burst
    // ************************************************************
    // the supply only sags once the tone has built up and loop current flows
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            age <= 2'h0;
            overload_pin <= 1'b0;
            supply_droop_pin <= 1'b0;
        end else begin
            age <= burst ? (age | {age[0], 1'b1}) : 2'h0;
            overload_pin <= burst;
            supply_droop_pin <= burst && age == 2'h3 && line_drive.offhook_hold;
        end
    end
endmodule

// File: testbench/line_cfg_asserts.sv
// concurrent checks on the ports of the line config block
module line_cfg_asserts
    import line_cfg_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic offhook_req,
    input wire line_drive_t line_drive
);
    // ************************************************************
    // properties
    // ************************************************************
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // both taken at one edge: the write lands on the next edge, bvalid is seen one edge later
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid)
        else $error("write not answered");
    read_answer_a: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
        else $error("read not answered");
    unmapped_read_a: assert property (s_axi_arvalid && !s_axi_rvalid && s_axi_araddr > 8'h10
        |=> s_axi_rresp == axi_slverr && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    term_onehot_a: assert property ($onehot(line_drive.term))
        else $error("termination not one-hot");
    hook_up_a: assert property (offhook_req [*6] |-> line_drive.offhook_hold)
        else $error("hook not held");
    hook_down_a: assert property (!offhook_req [*6] |-> !line_drive.offhook_hold)
        else $error("hook not released");
    cfg_hold_a: assert property ($changed({line_drive.ac_complex, line_drive.ringer_synth, line_drive.onhook_ramp})
        |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
        else $error("config output changed without a write");
    // a latched billing tone legally overrides the termination of the selected mode
    atten_mode_a: assert property (line_drive.tx_atten_1p7db |-> (line_drive.term == term_low_loop
        || line_drive.term == term_800_ohm) && !line_drive.tx_atten_4db)
        else $error("1.7 dB attenuation outside its mode");
    low_atten_a: assert property (line_drive.tx_atten_4db |-> line_drive.term == term_low_voltage
        || line_drive.term == term_800_ohm)
        else $error("4 dB attenuation outside its mode");
endmodule

bind line_cfg line_cfg_asserts chk_i (.clock(clock), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .offhook_req(offhook_req), .line_drive(line_drive));

// File: testbench/tb_line_cfg.sv
// self-checking bench for the line config block
module tb_line_cfg;
    timeunit 1ns;
    timeprecision 1ps;
    import line_cfg_pkg::*;
    typedef struct packed {logic [7:0] cfg; logic [7:0] dial; dc_term_t term; logic [2:0] att;} row_t;
    logic clock, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, offhook_req, overload_pin, supply_droop_pin;
    logic burst;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r, last_resp;
    line_drive_t line_drive;
    int n_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    // att holds 1.7 dB, 4 dB and headroom expectations
    row_t rows [10] = '{'{8'h08, 8'h00, term_default, 3'h0}, '{8'h08, 8'h08, term_low_loop, 3'h0},
        '{8'h08, 8'h01, term_low_voltage, 3'h0}, '{8'h08, 8'h09, term_low_loop, 3'h0},
        '{8'h0c, 8'h04, term_current_limit, 3'h1}, '{8'h0c, 8'h00, term_current_limit, 3'h0},
        '{8'h04, 8'h09, term_low_loop, 3'h4}, '{8'h00, 8'h09, term_low_voltage, 3'h2},
        '{8'h72, 8'h00, term_low_voltage, 3'h2}, '{8'h3a, 8'h00, term_default, 3'h0}};

    line_cfg #(.restore_count(16)) dut (.clock(clock), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .offhook_req(offhook_req), .overload_pin(overload_pin),
        .supply_droop_pin(supply_droop_pin), .line_drive(line_drive));
    line_side_model line_i (.clock(clock), .rst_n(rst_n), .burst(burst), .line_drive(line_drive),
        .overload_pin(overload_pin), .supply_droop_pin(supply_droop_pin));

    // ************************************************************
    // bus tasks and checking
    // ************************************************************
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] resp);
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) begin
                resp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) begin
                last_resp = s_axi_rresp;
                s_axi_rready <= 1'b0;
                chk(s_axi_rdata, e);
                break;
            end
        end
    endtask

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // a hang is cut short well beyond the few hundred cycles the run needs
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            give_verdict();
        end
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, offhook_req, burst} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        chk(32'(line_drive), 32'({term_default, 8'h00}));
        rd_chk(line_function_reg_off, 32'h00);
        rd_chk(line_config_reg_off, 32'h08);
        rd_chk(dial_control_reg_off, 32'h00);
        rd_chk(line_status_reg_off, 32'h20);
        rd_chk(8'h14, 32'h0);
        chk(32'(last_resp), 32'(axi_slverr));
        wr(8'h14, 8'hff, r);
        chk(32'(r), 32'(axi_slverr));
        offhook_req <= 1'b1;
        foreach (rows[i]) begin
            wr(line_config_reg_off, rows[i].cfg, r);
            wr(dial_control_reg_off, rows[i].dial, r);
            repeat (3) @(posedge clock);
            chk(32'(line_drive), 32'({rows[i].term, rows[i].att[2:1], rows[i].cfg[4], rows[i].cfg[1],
                rows[i].att[0], rows[i].cfg[6:5], 1'b1}));
            rd_chk(line_config_reg_off, {24'h0, rows[i].cfg});
        end
        wr(line_function_reg_off, 8'h80, r);
        burst <= 1'b1;
        repeat (10) @(posedge clock);
        chk(32'(line_drive), 32'({term_800_ohm, 4'h3, 1'b0, 2'h1, 1'b1}));
        rd_chk(line_status_reg_off, 32'h6a);
        burst <= 1'b0;
        repeat (6) @(posedge clock);
        rd_chk(line_status_reg_off, 32'h2a);
        wr(line_status_reg_off, 8'h0a, r);
        rd_chk(line_status_reg_off, 32'h2a);
        wr(line_function_reg_off, 8'h00, r);
        chk(32'(line_drive.term), 32'(term_800_ohm));
        repeat (24) @(posedge clock);
        chk(32'(line_drive.term), 32'(term_default));
        wr(line_status_reg_off, 8'h00, r);
        rd_chk(line_status_reg_off, 32'h20);
        burst <= 1'b1;
        repeat (10) @(posedge clock);
        burst <= 1'b0;
        repeat (6) @(posedge clock);
        rd_chk(line_status_reg_off, 32'h20);
        offhook_req <= 1'b0;
        repeat (4) @(posedge clock);
        chk(32'(line_drive.offhook_hold), 32'h0);
        offhook_req <= 1'b1;
        repeat (4) @(posedge clock);
        chk(32'(line_drive.offhook_hold), 32'h1);
        rst_n <= 1'b0;
        @(posedge clock);
        rst_n <= 1'b1;
        rd_chk(line_config_reg_off, 32'h08);
        rd_chk(line_drive_reg_off, 32'({term_default, 7'h00, 1'b1}));
        give_verdict();
    end
endmodule
